// File: design/cpuex_pkg.sv
// Constants and types shared by the exception and privilege unit
package cpuex_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PSW    = 6'h00;
  localparam logic [5:0] OFS_BPC    = 6'h04;
  localparam logic [5:0] OFS_BACKUP_STATUS_WORD   = 6'h08;
  localparam logic [5:0] OFS_IRQ_TABLE_BASE   = 6'h0C;
  localparam logic [5:0] OFS_EXCEPTION_TABLE_BASE   = 6'h10;
  localparam logic [5:0] OFS_FAST_IRQ_HANDLER_ADDRESS  = 6'h14;
  localparam logic [5:0] OFS_RSTSR0 = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h24;
  localparam logic [5:0] RSTSR_STEP = 6'h04;
  localparam int         RSTSR_NUM  = 3;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int          PSW_I_BIT     = 16;
  localparam int          PSW_PM_BIT    = 20;
  localparam int          PSW_IPL_LSB   = 24;
  localparam logic [31:0] PSW_I_MASK    = 32'h0001_0000;
  localparam logic [31:0] PSW_PM_MASK   = 32'h0010_0000;
  localparam logic [31:0] PSW_DEF_MASK  = 32'h0F13_000F;
  localparam logic [31:0] PSW_SUP_WMASK = 32'h0F03_000F;
  localparam logic [31:0] PSW_USR_WMASK = 32'h0000_000F;
  localparam logic [31:0] PSW_RESET     = 32'h0001_0000;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_VECTOR  = 32'hFFFF_FFFC;
  localparam logic [31:0] VOFS_PRIV     = 32'h0000_0050;
  localparam logic [31:0] VOFS_ACCESS   = 32'h0000_0054;
  localparam logic [31:0] VOFS_UNDEF    = 32'h0000_005C;
  localparam logic [31:0] VOFS_FPU      = 32'h0000_0064;
  localparam logic [31:0] VOFS_NMI      = 32'h0000_0078;
  localparam int          VEC_NUM_W     = 8;
  localparam int          TRAP_DEDICATED = 16;

  // ----------------------------------------------------------------
  // Exception causes and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CAUSE_NONE    = 4'h0,
    CAUSE_RESET   = 4'h1,
    CAUSE_NMI     = 4'h2,
    CAUSE_IRQ     = 4'h3,
    CAUSE_FASTIRQ = 4'h4,
    CAUSE_IACCESS = 4'h5,
    CAUSE_UNDEF   = 4'h6,
    CAUSE_PRIV    = 4'h7,
    CAUSE_TRAP    = 4'h8,
    CAUSE_OACCESS = 4'h9,
    CAUSE_FPU     = 4'hA
  } cpuex_cause_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FETCH = 2'b10
  } cpuex_state_t;

endpackage

// File: design/cpuex_unit.sv
// Exception sequencing, privilege mode and vector formation
// How it works
// - Reset and exceptions enter supervisor, clearing privilege.
// - Returns restore the mode held before exception.
// - Exception return with privilege bit set enters user.
// - Fast return with backup privilege set enters user.
// - User mode blocks privileged ops and writes to PSW control bits and backup registers, not to bases or fast handler.
// - Privileged instruction in user mode raises exception.
// - Trap instructions raise exception into supervisor mode.
// - Sixteen dedicated traps, up to 256 numbers reachable.
// - Protection violation raises access exception.
// - Maskable and non-maskable vectors use separate tables.
// - Undefined instruction always uses one vector.
// - Fixed priority from reset down to floating point.
// - Interrupt ordering comes from the interrupt controller.
// - Interrupt table base locates interrupt and trap vectors.
// - Exception table base locates system exception vectors.
// - Reset vector fixed at FFFF FFFCh.
// - Fast interrupt handler comes from its own register.
// - Interrupt accepted only above four-bit mask level.
// - Interrupt enable set at reset, cleared on exception.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
module cpuex_unit (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic [5:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        NMI_I,
  input  wire logic        IRQ_REQ_I,
  input  wire logic        FAST_IRQ_I,
  input  wire logic [3:0]  IRQ_PRIO_I,
  input  wire logic [7:0]  IRQ_VEC_I,
  input  wire logic        INSN_PROT_I,
  input  wire logic        UNDEF_INSN_I,
  input  wire logic        PRIV_INSN_I,
  input  wire logic        TRAP_I,
  input  wire logic [7:0]  TRAP_NUM_I,
  input  wire logic        OPERAND_PROT_I,
  input  wire logic        FPU_EXC_I,
  input  wire logic [31:0] CURRENT_PC_I,
  input  wire logic        RTE_I,
  input  wire logic [31:0] RTE_PSW_I,
  input  wire logic        FAST_IRQ_RETURN_INSTR_I,
  input  wire logic [23:0] RESET_STATUS_I,
  input  wire logic [31:0] VEC_DATA_I,
  input  wire logic        VEC_VALID_I,
  output logic             VEC_FETCH_REQ_O,
  output logic      [31:0] VEC_FETCH_ADDR_O,
  output logic             PC_LOAD_O,
  output logic      [31:0] NEW_PC_O,
  output logic             EXC_ACK_O,
  output logic             IRQ_ACK_O,
  output logic      [3:0]  EXC_CAUSE_O,
  output logic      [31:0] SAVED_PSW_O,
  output logic      [31:0] SAVED_PC_O,
  output logic             BUSY_O,
  output logic             USER_MODE_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cpuex_pkg::cpuex_state_t state_reg;
  cpuex_pkg::cpuex_state_t state_next;
  cpuex_pkg::cpuex_cause_t cause_w;
  cpuex_pkg::cpuex_cause_t cause_reg;
  logic [31:0] psw_reg;
  logic [31:0] psw_next;
  logic [31:0] bpc_reg;
  logic [31:0] bpc_next;
  logic [31:0] backup_status_word_reg;
  logic [31:0] backup_status_word_next;
  logic [31:0] irq_table_base_reg;
  logic [31:0] exception_table_base_reg;
  logic [31:0] fast_irq_handler_address_reg;
  logic [7:0]  rstsr_reg [cpuex_pkg::RSTSR_NUM];
  logic        cap_done_reg;
  logic [31:0] fetch_addr_reg;
  logic        pc_load_reg;
  logic [31:0] new_pc_reg;
  logic [31:0] saved_psw_reg;
  logic [31:0] saved_pc_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // Write merge under byte enables and an allowed-bit mask
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be,
                                         input logic [31:0] allow);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & allow;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // ----------------------------------------------------------------
  // Mode and exception requests
  // ----------------------------------------------------------------
  wire         user_mode = psw_reg[cpuex_pkg::PSW_PM_BIT];
  wire         psw_ien   = psw_reg[cpuex_pkg::PSW_I_BIT];
  wire [3:0]   irq_mask_level       = psw_reg[cpuex_pkg::PSW_IPL_LSB +: 4];
  wire         in_idle   = (state_reg == cpuex_pkg::ST_IDLE);
  wire         irq_ok    = IRQ_REQ_I & psw_ien & (IRQ_PRIO_I > irq_mask_level);
  wire         priv_exc  = PRIV_INSN_I & user_mode;

  // one request, fixed rank from NMI down to floating point
  assign cause_w =
      NMI_I                    ? cpuex_pkg::CAUSE_NMI     :
      (irq_ok & FAST_IRQ_I)    ? cpuex_pkg::CAUSE_FASTIRQ :
      irq_ok                   ? cpuex_pkg::CAUSE_IRQ     :
      INSN_PROT_I              ? cpuex_pkg::CAUSE_IACCESS :
      UNDEF_INSN_I             ? cpuex_pkg::CAUSE_UNDEF   :
      priv_exc                 ? cpuex_pkg::CAUSE_PRIV    :
      TRAP_I                   ? cpuex_pkg::CAUSE_TRAP    :
      OPERAND_PROT_I           ? cpuex_pkg::CAUSE_OACCESS :
      FPU_EXC_I                ? cpuex_pkg::CAUSE_FPU     :
                                 cpuex_pkg::CAUSE_NONE;

  wire exc_take  = in_idle & (cause_w != cpuex_pkg::CAUSE_NONE);
  wire is_fast   = (cause_w == cpuex_pkg::CAUSE_FASTIRQ);
  // Returns only count when nothing is being entered that cycle
  wire rte_fire  = in_idle & ~exc_take & RTE_I;
  wire fast_irq_return_instr_fire = in_idle & ~exc_take & ~RTE_I & FAST_IRQ_RETURN_INSTR_I;

  // ----------------------------------------------------------------
  // Vector formation
  // ----------------------------------------------------------------
  wire [31:0] irq_ofs  = {22'h00_0000, IRQ_VEC_I, 2'b00};
  wire [31:0] trap_ofs = {22'h00_0000, TRAP_NUM_I, 2'b00};

  wire [31:0] vec_addr =
      (cause_w == cpuex_pkg::CAUSE_NMI)  ? exception_table_base_reg + cpuex_pkg::VOFS_NMI :
      (cause_w == cpuex_pkg::CAUSE_IRQ)  ? irq_table_base_reg + irq_ofs :
      // trap number indexes the full table
      (cause_w == cpuex_pkg::CAUSE_TRAP) ? irq_table_base_reg + trap_ofs :
      // both access kinds share the access vector
      ((cause_w == cpuex_pkg::CAUSE_IACCESS) |
       (cause_w == cpuex_pkg::CAUSE_OACCESS))
                                      ? exception_table_base_reg + cpuex_pkg::VOFS_ACCESS :
      (cause_w == cpuex_pkg::CAUSE_UNDEF) ? exception_table_base_reg + cpuex_pkg::VOFS_UNDEF :
      (cause_w == cpuex_pkg::CAUSE_PRIV)  ? exception_table_base_reg + cpuex_pkg::VOFS_PRIV :
                                         exception_table_base_reg + cpuex_pkg::VOFS_FPU;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire bus_req   = AVS_READ_I | AVS_WRITE_I;
  wire wr_fire   = AVS_WRITE_I & ack_reg;
  wire sel_psw   = (AVS_ADDRESS_I == cpuex_pkg::OFS_PSW);
  wire sel_bpc   = (AVS_ADDRESS_I == cpuex_pkg::OFS_BPC);
  wire sel_backup_status_word  = (AVS_ADDRESS_I == cpuex_pkg::OFS_BACKUP_STATUS_WORD);
  wire sel_irq_table_base  = (AVS_ADDRESS_I == cpuex_pkg::OFS_IRQ_TABLE_BASE);
  wire sel_exception_table_base  = (AVS_ADDRESS_I == cpuex_pkg::OFS_EXCEPTION_TABLE_BASE);
  wire sel_fast_irq_handler_address = (AVS_ADDRESS_I == cpuex_pkg::OFS_FAST_IRQ_HANDLER_ADDRESS);
  wire sel_stat  = (AVS_ADDRESS_I == cpuex_pkg::OFS_STATUS);
  wire sel_rst0  = (AVS_ADDRESS_I == cpuex_pkg::OFS_RSTSR0);
  wire sel_rst1  = (AVS_ADDRESS_I ==
                    cpuex_pkg::OFS_RSTSR0 + cpuex_pkg::RSTSR_STEP);
  wire sel_rst2  = (AVS_ADDRESS_I ==
                    cpuex_pkg::OFS_RSTSR0 + 6'(2 * cpuex_pkg::RSTSR_STEP));
  wire [31:0] status_word = {25'h000_0000, user_mode, state_reg, cause_reg};

  wire [31:0] rd_mux =
      sel_psw   ? psw_reg :
      sel_bpc   ? bpc_reg :
      sel_backup_status_word  ? backup_status_word_reg :
      sel_irq_table_base  ? irq_table_base_reg :
      sel_exception_table_base  ? exception_table_base_reg :
      sel_fast_irq_handler_address ? fast_irq_handler_address_reg :
      sel_rst0  ? {24'h00_0000, rstsr_reg[0]} :
      sel_rst1  ? {24'h00_0000, rstsr_reg[1]} :
      sel_rst2  ? {24'h00_0000, rstsr_reg[2]} :
      sel_stat  ? status_word :
                  32'h0000_0000;

  // user writes limited to flag bits
  wire [31:0] psw_wmask = user_mode ? cpuex_pkg::PSW_USR_WMASK
                                    : cpuex_pkg::PSW_SUP_WMASK;
  wire [31:0] psw_wr_v  = wmerge(psw_reg, AVS_WRITEDATA_I,
                                 AVS_BYTEENABLE_I, psw_wmask);
  // backup registers untouched from user mode
  wire bk_wr_ok = wr_fire & ~user_mode;

  // ----------------------------------------------------------------
  // Next values; hardware events win over bus writes
  // ----------------------------------------------------------------
  // supervisor on entry
  // traps enter through the same path
  // stacked privilege bit taken as is
  // backup privilege bit taken as is
  assign psw_next =
      exc_take  ? psw_reg & ~(cpuex_pkg::PSW_PM_MASK | cpuex_pkg::PSW_I_MASK) :
      rte_fire  ? RTE_PSW_I & cpuex_pkg::PSW_DEF_MASK :
      fast_irq_return_instr_fire ? backup_status_word_reg :
      (wr_fire & sel_psw) ? psw_wr_v :
                  psw_reg;

  assign backup_status_word_next =
      (exc_take & is_fast) ? psw_reg :
      (bk_wr_ok & sel_backup_status_word)
          ? wmerge(backup_status_word_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                   cpuex_pkg::PSW_DEF_MASK) :
            backup_status_word_reg;

  assign bpc_next =
      (exc_take & is_fast) ? CURRENT_PC_I :
      (bk_wr_ok & sel_bpc)
          ? wmerge(bpc_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                   32'hFFFF_FFFF) :
            bpc_reg;

  // Fast interrupts skip the table read
  assign state_next =
      (exc_take & ~is_fast)       ? cpuex_pkg::ST_FETCH :
      (in_idle | VEC_VALID_I)     ? cpuex_pkg::ST_IDLE :
                                    cpuex_pkg::ST_FETCH;

  // ----------------------------------------------------------------
  // Sequencer and core registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      psw_reg        <= cpuex_pkg::PSW_RESET;
      bpc_reg        <= cpuex_pkg::WORD_RESET;
      backup_status_word_reg       <= cpuex_pkg::WORD_RESET;
      // every reset cause uses this one vector
      state_reg      <= cpuex_pkg::ST_FETCH;
      fetch_addr_reg <= cpuex_pkg::RESET_VECTOR;
      cause_reg      <= cpuex_pkg::CAUSE_RESET;
    end else begin
      psw_reg   <= psw_next;
      bpc_reg   <= bpc_next;
      backup_status_word_reg  <= backup_status_word_next;
      state_reg <= state_next;
      if (exc_take) begin
        fetch_addr_reg <= vec_addr;
        cause_reg      <= cause_w;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      pc_load_reg   <= 1'b0;
      new_pc_reg    <= cpuex_pkg::WORD_RESET;
      saved_psw_reg <= cpuex_pkg::WORD_RESET;
      saved_pc_reg  <= cpuex_pkg::WORD_RESET;
    end else begin
      // fast handler straight from its register
      pc_load_reg <= (exc_take & is_fast) | fast_irq_return_instr_fire |
                     (~in_idle & VEC_VALID_I);
      new_pc_reg  <= (exc_take & is_fast) ? fast_irq_handler_address_reg :
                     fast_irq_return_instr_fire            ? bpc_reg :
                     (~in_idle & VEC_VALID_I) ? VEC_DATA_I : new_pc_reg;
      if (exc_take & ~is_fast) begin
        saved_psw_reg <= psw_reg;
        saved_pc_reg  <= CURRENT_PC_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-owned bases and reset status capture
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      irq_table_base_reg  <= cpuex_pkg::WORD_RESET;
      exception_table_base_reg  <= cpuex_pkg::WORD_RESET;
      fast_irq_handler_address_reg <= cpuex_pkg::WORD_RESET;
    end else if (wr_fire) begin
      if (sel_irq_table_base) begin
        irq_table_base_reg <= wmerge(irq_table_base_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                           32'hFFFF_FFFF);
      end else if (sel_exception_table_base) begin
        exception_table_base_reg <= wmerge(exception_table_base_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                           32'hFFFF_FFFF);
      end else if (sel_fast_irq_handler_address) begin
        fast_irq_handler_address_reg <= wmerge(fast_irq_handler_address_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                            32'hFFFF_FFFF);
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      cap_done_reg <= 1'b0;
    end else begin
      cap_done_reg <= 1'b1;
    end
  end

  // cause bytes latched once after release
  for (genvar g = 0; g < cpuex_pkg::RSTSR_NUM; g++) begin : g_rstsr
    always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
        rstsr_reg[g] <= 8'h00;
      end else if (!cap_done_reg) begin
        rstsr_reg[g] <= RESET_STATUS_I[g * 8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle for every access
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ack_reg   <= 1'b0;
      rdata_reg <= cpuex_pkg::WORD_RESET;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (AVS_READ_I & ~ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
  assign AVS_READDATA_O    = rdata_reg;
  assign VEC_FETCH_REQ_O   = (state_reg == cpuex_pkg::ST_FETCH);
  assign VEC_FETCH_ADDR_O  = fetch_addr_reg;
  assign PC_LOAD_O         = pc_load_reg;
  assign NEW_PC_O          = new_pc_reg;
  assign EXC_ACK_O         = exc_take;
  assign IRQ_ACK_O         = exc_take & ((cause_w == cpuex_pkg::CAUSE_IRQ) |
                                         is_fast);
  assign EXC_CAUSE_O       = cause_reg;
  assign SAVED_PSW_O       = saved_psw_reg;
  assign SAVED_PC_O        = saved_pc_reg;
  assign BUSY_O            = ~in_idle;
  assign USER_MODE_O       = user_mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_vector_a: assert property (
    @(posedge CLOCK_I) $fell(RESET_I) |->
      VEC_FETCH_REQ_O && VEC_FETCH_ADDR_O == 32'hFFFF_FFFC && !USER_MODE_O)
    else $error("reset vector fetch wrong");

  entry_super_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      EXC_ACK_O |=> !USER_MODE_O && !psw_reg[16])
    else $error("entry left user mode or enable set");

  rte_restore_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      rte_fire |=> USER_MODE_O == $past(RTE_PSW_I[20]))
    else $error("exception return mode wrong");

  fast_irq_return_instr_restore_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      fast_irq_return_instr_fire |=> USER_MODE_O == $past(backup_status_word_reg[20]) &&
                    PC_LOAD_O && NEW_PC_O == $past(bpc_reg))
    else $error("fast return restore wrong");

  user_bpc_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      wr_fire && sel_bpc && USER_MODE_O && !EXC_ACK_O |=> $stable(bpc_reg))
    else $error("backup PC written in user mode");

  priv_trap_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      in_idle && PRIV_INSN_I && USER_MODE_O && !NMI_I && !irq_ok &&
      !INSN_PROT_I && !UNDEF_INSN_I |=>
        EXC_CAUSE_O == 4'h7 && VEC_FETCH_ADDR_O == exception_table_base_reg + 32'h50)
    else $error("privileged exception not raised");

  trap_vector_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      EXC_ACK_O && cause_w == cpuex_pkg::CAUSE_TRAP |=>
        VEC_FETCH_REQ_O &&
        VEC_FETCH_ADDR_O == $past(irq_table_base_reg) + {22'h0, $past(TRAP_NUM_I), 2'b00})
    else $error("trap vector address wrong");

  irq_mask_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      IRQ_ACK_O |-> IRQ_PRIO_I > psw_reg[27:24] && psw_reg[16])
    else $error("interrupt accepted at or below mask");

  fast_vector_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      EXC_ACK_O && FAST_IRQ_I && cause_w == cpuex_pkg::CAUSE_FASTIRQ |=>
        PC_LOAD_O && NEW_PC_O == $past(fast_irq_handler_address_reg) && !VEC_FETCH_REQ_O)
    else $error("fast interrupt vector wrong");

  nmi_first_a: assert property (
    @(posedge CLOCK_I) disable iff (RESET_I)
      EXC_ACK_O && NMI_I |=> EXC_CAUSE_O == 4'h2 &&
        VEC_FETCH_ADDR_O == $past(exception_table_base_reg) + 32'h78)
    else $error("non-maskable interrupt not ranked first");

endmodule

// File: verification/cpuex_vec_mem.sv
// Vector word source standing in for the instruction pipeline
module cpuex_vec_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  lat_i,
  output logic             valid_o,
  output logic      [31:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg;
  wire        hit = req_i && !valid_o && cnt_reg == lat_i;
  // Idle data toggles so a stale word never passes for a fresh one
  always_ff @(posedge clk_i) begin
    valid_o <= !rst_i && hit;
    cnt_reg <= (rst_i || !req_i || hit) ? 4'h0 : cnt_reg + 4'h1;
    data_o  <= rst_i ? 32'h0 : (hit ? addr_i ^ 32'hA5A5_0000 : ~data_o);
  end
endmodule

// File: verification/cpuex_unit_bench.sv
// Self-checking bench for the exception and privilege unit
module cpuex_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK_I, RESET_I, AVS_READ_I, AVS_WRITE_I, RTE_I, FAST_IRQ_RETURN_INSTR_I;
  logic VEC_VALID_I;
  logic [5:0] AVS_ADDRESS_I;
  logic [3:0] AVS_BYTEENABLE_I, IRQ_PRIO_I, lat;
  logic [7:0] IRQ_VEC_I, TRAP_NUM_I;
  logic [31:0] AVS_WRITEDATA_I, CURRENT_PC_I, RTE_PSW_I, VEC_DATA_I, q;
  logic [31:0] irq_table_base, exception_table_base, fast_irq_handler_address;
  logic [23:0] RESET_STATUS_I;
  logic [8:0] rq;
  wire NMI_I, IRQ_REQ_I, FAST_IRQ_I, INSN_PROT_I, UNDEF_INSN_I;
  wire PRIV_INSN_I, TRAP_I, OPERAND_PROT_I, FPU_EXC_I;
  wire [31:0] AVS_READDATA_O, VEC_FETCH_ADDR_O, NEW_PC_O, SAVED_PSW_O;
  wire [31:0] SAVED_PC_O;
  wire AVS_WAITREQUEST_O, VEC_FETCH_REQ_O, PC_LOAD_O, EXC_ACK_O;
  wire IRQ_ACK_O, BUSY_O, USER_MODE_O;
  wire [3:0] EXC_CAUSE_O;
  int seed = 54;
  int bad_count = 0;
  int n_checks = 0;
  // Request bits, highest rank first
  assign {NMI_I, IRQ_REQ_I, FAST_IRQ_I, INSN_PROT_I, UNDEF_INSN_I,
          PRIV_INSN_I, TRAP_I, OPERAND_PROT_I, FPU_EXC_I} = rq;
  cpuex_unit i_cpuex_unit (.*);
  cpuex_vec_mem i_cpuex_vec_mem (.clk_i(CLOCK_I), .rst_i(RESET_I),
    .req_i(VEC_FETCH_REQ_O), .addr_i(VEC_FETCH_ADDR_O), .lat_i(lat),
    .valid_o(VEC_VALID_I), .data_o(VEC_DATA_I));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function logic [31:0] vw(input logic [31:0] a);
    return a ^ 32'hA5A5_0000;
  endfunction
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    do @(negedge CLOCK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    // Completing edge: read data is held across it
    @(posedge CLOCK_I);
    q = AVS_READDATA_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task pcw(input logic [31:0] pc, input logic [3:0] c);
    do @(negedge CLOCK_I); while (PC_LOAD_O !== 1'b1);
    chk(NEW_PC_O, pc);
    chk({28'h0, EXC_CAUSE_O}, {28'h0, c});
    chk({31'h0, USER_MODE_O}, 32'h0);
    chk({31'h0, BUSY_O}, 32'h0);
  endtask
  // Requests are held until taken, as the far side must
  task ex(input logic [8:0] r, input logic [31:0] pc, input logic [3:0] c);
    @(posedge CLOCK_I);
    rq <= r;
    lat <= 4'($random(seed));
    do @(negedge CLOCK_I); while ((EXC_ACK_O | IRQ_ACK_O) !== 1'b1);
    @(posedge CLOCK_I);
    rq <= 9'h0;
    pcw(pc, c);
  endtask
  task ret(input logic f, input logic [31:0] p, input logic u);
    @(posedge CLOCK_I);
    RTE_I <= !f;
    FAST_IRQ_RETURN_INSTR_I <= f;
    RTE_PSW_I <= p;
    @(posedge CLOCK_I);
    RTE_I <= 1'b0;
    FAST_IRQ_RETURN_INSTR_I <= 1'b0;
    @(negedge CLOCK_I);
    chk({31'h0, USER_MODE_O}, {31'h0, u});
  endtask
  initial begin
    CLOCK_I = 1'b0;
    forever #5 CLOCK_I = ~CLOCK_I;
  end
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    bad_count++;
    give_verdict;
  end
  initial begin
    RESET_I = 1'b1;
    {AVS_READ_I, AVS_WRITE_I, RTE_I, FAST_IRQ_RETURN_INSTR_I} = 4'h0;
    AVS_ADDRESS_I = 6'h00;
    AVS_WRITEDATA_I = 32'h0;
    AVS_BYTEENABLE_I = 4'hF;
    {IRQ_PRIO_I, IRQ_VEC_I, TRAP_NUM_I, RTE_PSW_I, rq, lat} = '0;
    CURRENT_PC_I = $random(seed);
    RESET_STATUS_I = 24'($random(seed));
    irq_table_base = $random(seed) & 32'hFFFF_FC00;
    exception_table_base = $random(seed) & 32'hFFFF_FF00;
    fast_irq_handler_address = $random(seed);
    repeat (20) @(posedge CLOCK_I);
    RESET_I <= 1'b0;
    pcw(vw(cpuex_pkg::RESET_VECTOR), cpuex_pkg::CAUSE_RESET);
    rd(cpuex_pkg::OFS_PSW, cpuex_pkg::PSW_RESET);
    for (int g = 0; g < 3; g++)
      rd(cpuex_pkg::OFS_RSTSR0 + 6'(4 * g), {24'h0, RESET_STATUS_I[8*g+:8]});
    rd(6'h3C, 32'h0);
    bus(1'b1, cpuex_pkg::OFS_IRQ_TABLE_BASE, irq_table_base);
    bus(1'b1, cpuex_pkg::OFS_EXCEPTION_TABLE_BASE, exception_table_base);
    bus(1'b1, cpuex_pkg::OFS_FAST_IRQ_HANDLER_ADDRESS, fast_irq_handler_address);
    $display("reset and map test done");
    TRAP_NUM_I <= 8'($random(seed));
    ex(9'h015, vw(exception_table_base + cpuex_pkg::VOFS_UNDEF), cpuex_pkg::CAUSE_UNDEF);
    rd(cpuex_pkg::OFS_PSW, 32'h0);
    // Privileged op in supervisor must not outrank the trap
    ex(9'h00E, vw(irq_table_base + {TRAP_NUM_I, 2'b00}), cpuex_pkg::CAUSE_TRAP);
    ex(9'h003, vw(exception_table_base + cpuex_pkg::VOFS_ACCESS), cpuex_pkg::CAUSE_OACCESS);
    ex(9'h030, vw(exception_table_base + cpuex_pkg::VOFS_ACCESS), cpuex_pkg::CAUSE_IACCESS);
    ex(9'h001, vw(exception_table_base + cpuex_pkg::VOFS_FPU), cpuex_pkg::CAUSE_FPU);
    ex(9'h120, vw(exception_table_base + cpuex_pkg::VOFS_NMI), cpuex_pkg::CAUSE_NMI);
    $display("priority test done");
    bus(1'b1, cpuex_pkg::OFS_PSW, 32'h0501_0000);
    IRQ_PRIO_I <= 4'h5;
    IRQ_VEC_I <= 8'($random(seed));
    rq <= 9'h080;
    repeat (6) begin
      @(negedge CLOCK_I);
      chk({31'h0, IRQ_ACK_O}, 32'h0);
    end
    @(posedge CLOCK_I);
    rq <= 9'h0;
    IRQ_PRIO_I <= 4'h6;
    ex(9'h080, vw(irq_table_base + {IRQ_VEC_I, 2'b00}), cpuex_pkg::CAUSE_IRQ);
    ret(1'b0, 32'h0011_0000, 1'b1);
    bus(1'b1, cpuex_pkg::OFS_PSW, 32'hFFFF_FFFF);
    rd(cpuex_pkg::OFS_PSW, 32'h0011_000F);
    bus(1'b1, cpuex_pkg::OFS_BPC, 32'h0000_1234);
    rd(cpuex_pkg::OFS_BPC, 32'h0);
    ex(9'h008, vw(exception_table_base + cpuex_pkg::VOFS_PRIV), cpuex_pkg::CAUSE_PRIV);
    chk(SAVED_PSW_O, 32'h0011_000F);
    chk(SAVED_PC_O, CURRENT_PC_I);
    ret(1'b0, SAVED_PSW_O, 1'b1);
    $display("user mode test done");
    @(posedge CLOCK_I);
    IRQ_PRIO_I <= 4'hF;
    ex(9'h0C0, fast_irq_handler_address, cpuex_pkg::CAUSE_FASTIRQ);
    ret(1'b1, 32'h0, 1'b1);
    chk(NEW_PC_O, CURRENT_PC_I);
    rd(cpuex_pkg::OFS_STATUS, 32'h0000_0054);
    $display("fast interrupt test done");
    give_verdict;
  end
endmodule
